// *** hdl/bss_sram_ctrl.sv ***
// Burst synchronous SRAM: input registers, burst counter, array and data drivers.
`timescale 1ns/1ps
module bss_sram_ctrl #(
    parameter int ADDR_W = bss_pkg::ADDR_W,
    parameter int DATA_W = bss_pkg::DATA_W,
    parameter int WQ_DEPTH = bss_pkg::WQ_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic [DATA_W-1:0] shared_data_bus_in,
    output logic [DATA_W-1:0] shared_data_bus_out,
    output logic shared_data_bus_oe,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic select_active_high,
    input wire logic select_active_low_n,
    input wire logic start_from_processor_n,
    input wire logic start_from_cache_ctrl_n,
    input wire logic burst_advance_n,
    output logic write_queue_ready
);
    localparam int BW = bss_pkg::BURST_W;
    localparam int WORDS = 1 << ADDR_W;
    localparam int QW = ADDR_W + DATA_W;

    if (ADDR_W <= BW || DATA_W < 1) begin : g_chk
        $error("Address must be wider than the burst counter.");
    end

    // ------------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_q;
    logic we_n_q;
    logic sel_hi_q;
    logic sel_lo_n_q;
    logic tsp_n_q;
    logic tsc_n_q;
    logic adv_n_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            addr_q <= '0;
            data_q <= '0;
            we_n_q <= 1'b1;
            sel_hi_q <= 1'b0;
            sel_lo_n_q <= 1'b1;
            tsp_n_q <= 1'b1;
            tsc_n_q <= 1'b1;
            adv_n_q <= 1'b1;
        end else begin
            addr_q <= word_address;
            data_q <= shared_data_bus_in;
            we_n_q <= write_strobe_n;
            sel_hi_q <= select_active_high;
            sel_lo_n_q <= select_active_low_n;
            tsp_n_q <= start_from_processor_n;
            tsc_n_q <= start_from_cache_ctrl_n;
            adv_n_q <= burst_advance_n;
        end
    end

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    bss_pkg::bss_state_t state_r;
    logic [ADDR_W-1:BW] base_r;
    logic [BW-1:0] cnt_r;
    logic [BW-1:0] cnt_nxt;
    logic [BW-1:0] start_lo_r;
    logic start_c;
    logic sel_c;
    logic load_c;
    logic desel_c;
    logic cont_c;
    logic adv_c;
    logic acc_c;
    logic acc_wr_c;
    logic acc_rd_c;
    logic [ADDR_W-1:0] acc_addr;

    assign start_c = !tsp_n_q || !tsc_n_q;
    assign sel_c = sel_hi_q && !sel_lo_n_q;
    assign load_c = start_c && sel_c;
    assign desel_c = start_c && !sel_c;
    assign cont_c = !start_c && (state_r == bss_pkg::BSS_BURST);
    assign adv_c = cont_c && !adv_n_q;
    assign acc_c = load_c || cont_c;
    assign acc_wr_c = acc_c && tsp_n_q && !we_n_q;
    assign acc_rd_c = acc_c && !acc_wr_c;

    always_comb begin
        if (load_c) begin
            cnt_nxt = addr_q[BW-1:0];
        end else if (adv_c) begin
            cnt_nxt = cnt_r + 1'b1;
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    assign acc_addr = load_c ? addr_q : {base_r, cnt_nxt};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= bss_pkg::BSS_IDLE;
        end else if (desel_c) begin
            state_r <= bss_pkg::BSS_IDLE;
        end else if (load_c) begin
            state_r <= bss_pkg::BSS_BURST;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            base_r <= '0;
            start_lo_r <= '0;
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            if (load_c) begin
                base_r <= addr_q[ADDR_W-1:BW];
                start_lo_r <= addr_q[BW-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Array, write queue and data drivers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [0:WORDS-1];
    logic [DATA_W-1:0] rd_data_r;
    logic drive_r;

    bss_wq_if #(.W(QW)) wq ();

    bss_wq_fifo #(.W(QW), .DEPTH(WQ_DEPTH)) u_wq (
        .clk_sys(clk_sys),
        .reset(reset),
        .q(wq.fifo)
    );

    assign wq.in_valid = acc_wr_c;
    assign wq.in_data = {acc_addr, data_q};
    // A read owns the array port; queued writes drain in the gaps.
    assign wq.out_ready = !acc_rd_c;

    always_ff @(posedge clk_sys) begin
        if (wq.out_valid && wq.out_ready) begin
            mem_r[wq.out_data[QW-1:DATA_W]] <= wq.out_data[DATA_W-1:0];
        end
        if (acc_rd_c) begin
            rd_data_r <= mem_r[acc_addr];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drive_r <= 1'b0;
            write_queue_ready <= 1'b0;
        end else begin
            drive_r <= acc_rd_c && we_n_q;
            write_queue_ready <= wq.in_ready;
        end
    end

    assign shared_data_bus_out = rd_data_r;
    // Output enable is combinational onto the driver enable on purpose.
    assign shared_data_bus_oe = drive_r && !output_enable_n;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_load_cnt;
        @(posedge clk_sys) disable iff (reset)
        load_c |=> cnt_r == $past(addr_q[BW-1:0]);
    endproperty
    a_load_cnt: assert property (p_load_cnt) else $error("Burst counter not loaded.");

    property p_advance;
        @(posedge clk_sys) disable iff (reset)
        adv_c |=> cnt_r == BW'($past(cnt_r) + 1);
    endproperty
    a_advance: assert property (p_advance) else $error("Burst counter did not step.");

    property p_suspend;
        @(posedge clk_sys) disable iff (reset)
        cont_c && adv_n_q |=> $stable(cnt_r) && $stable(base_r);
    endproperty
    a_suspend: assert property (p_suspend) else $error("Suspend moved the address.");

    property p_wrap;
        @(posedge clk_sys) disable iff (reset)
        load_c ##1 adv_c[*4] |=> cnt_r == start_lo_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Burst did not wrap to start.");

    property p_desel;
        @(posedge clk_sys) disable iff (reset)
        desel_c |=> state_r == bss_pkg::BSS_IDLE && !drive_r && $stable(base_r);
    endproperty
    a_desel: assert property (p_desel) else $error("Deselect started an access.");

    property p_sel_ignored;
        @(posedge clk_sys) disable iff (reset)
        cont_c && !sel_c |=> state_r == bss_pkg::BSS_BURST;
    endproperty
    a_sel_ignored: assert property (p_sel_ignored) else $error("Select sampled mid-burst.");

    property p_tsp_read;
        @(posedge clk_sys) disable iff (reset)
        !tsp_n_q && sel_c |-> !wq.in_valid ##1 cnt_r == $past(addr_q[BW-1:0]);
    endproperty
    a_tsp_read: assert property (p_tsp_read) else $error("Processor start did not read.");

    property p_tsc_write;
        @(posedge clk_sys) disable iff (reset)
        tsp_n_q && !tsc_n_q && sel_c && !we_n_q |-> wq.in_valid && wq.in_data[QW-1:DATA_W] == addr_q;
    endproperty
    a_tsc_write: assert property (p_tsc_write) else $error("Controller write not queued.");

    property p_wr_no_drive;
        @(posedge clk_sys) disable iff (reset)
        !we_n_q |=> !shared_data_bus_oe;
    endproperty
    a_wr_no_drive: assert property (p_wr_no_drive) else $error("Drivers on during write.");

    property p_oe_gate;
        @(posedge clk_sys) disable iff (reset)
        shared_data_bus_oe |-> !output_enable_n && $past(acc_rd_c);
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("Drivers on without a read.");

    property p_cont_write;
        @(posedge clk_sys) disable iff (reset)
        adv_c && !we_n_q |-> wq.in_valid && wq.in_data[QW-1:DATA_W] == {base_r, cnt_r + BW'(1)};
    endproperty
    a_cont_write: assert property (p_cont_write) else $error("Continue write missed the next address.");

    property p_susp_write;
        @(posedge clk_sys) disable iff (reset)
        cont_c && adv_n_q && !we_n_q |-> wq.in_valid && wq.in_data[QW-1:DATA_W] == {base_r, cnt_r};
    endproperty
    a_susp_write: assert property (p_susp_write) else $error("Suspend write left the current address.");

    property p_read_drive;
        @(posedge clk_sys) disable iff (reset)
        acc_c && we_n_q |=> drive_r;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("Read left the drivers off.");

    property p_tsp_no_write;
        @(posedge clk_sys) disable iff (reset)
        !tsp_n_q |-> !wq.in_valid;
    endproperty
    a_tsp_no_write: assert property (p_tsp_no_write) else $error("Processor start queued a write.");

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (reset)
        state_r == bss_pkg::BSS_IDLE && !start_c |-> !wq.in_valid ##1 !drive_r;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Access started while idle.");

    property p_load_base;
        @(posedge clk_sys) disable iff (reset)
        load_c |=> base_r == $past(addr_q[ADDR_W-1:BW]) && state_r == bss_pkg::BSS_BURST;
    endproperty
    a_load_base: assert property (p_load_base) else $error("Base address not loaded.");

    property p_base_hold;
        @(posedge clk_sys) disable iff (reset)
        cont_c |=> $stable(base_r) && $stable(start_lo_r);
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("Upper address moved inside a burst.");

    property p_wr_off;
        @(posedge clk_sys) disable iff (reset)
        acc_wr_c |=> !drive_r;
    endproperty
    a_wr_off: assert property (p_wr_off) else $error("Drivers armed by a write.");

    property p_desel_stops;
        @(posedge clk_sys) disable iff (reset)
        desel_c ##1 (!start_c) |-> !acc_c;
    endproperty
    a_desel_stops: assert property (p_desel_stops) else $error("Burst went on after a deselect.");

    property p_read_begin;
        @(posedge clk_sys) disable iff (reset)
        load_c && !acc_wr_c;
    endproperty
    c_read_begin: cover property (p_read_begin);

    property p_write_begin;
        @(posedge clk_sys) disable iff (reset)
        load_c && acc_wr_c;
    endproperty
    c_write_begin: cover property (p_write_begin);

    property p_full_burst;
        @(posedge clk_sys) disable iff (reset)
        load_c ##1 adv_c[*3];
    endproperty
    c_full_burst: cover property (p_full_burst);

    property p_wait_state;
        @(posedge clk_sys) disable iff (reset)
        adv_c ##1 (cont_c && adv_n_q);
    endproperty
    c_wait_state: cover property (p_wait_state);
endmodule : bss_sram_ctrl

// *** hdl/bss_pkg.sv ***
// Constants and types shared by the burst synchronous SRAM controller.
// Functional notes
// - Array holds 32768 words of 9 bits, 15-bit address, one shared data bus.
// - Address, data and all controls except output enable are registered on rising edge.
// - Processor start low aborts any burst and reads the new address, ignoring others.
// - Controller start low with processor start high begins read or write by strobe.
// - Chip selects are evaluated only on edges with a start low.
// - Advance low with both starts high steps the burst address before the access.
// - Advance high with both starts high repeats the access at the current address.
// - Two-bit burst counter loads from the two lowest address bits and steps only them.
// - After four beats the low address bits wrap back to the starting value.
// - Continue cycle accesses the next burst address, writing on strobe low.
// - Suspend cycle accesses the current burst address again, writing on strobe low.
// - Chip select false with a start low deselects; nothing accessed, nothing loaded.
// - Array writes are timed internally from the rising clock edge.
// - Output enable gates the data drivers directly, without the clock.
// - Read when strobe high or processor start low; write only otherwise.
// - Strobe sampled low keeps data drivers off whatever output enable says.
package bss_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int WORDS = 32768;
    localparam int BURST_W = 2;
    localparam int WQ_DEPTH = 16;
    localparam int CLK_PERIOD_NS = 25;

    typedef enum logic [0:0] {
        BSS_IDLE = 1'b0,
        BSS_BURST = 1'b1
    } bss_state_t;
endpackage : bss_pkg

// *** hdl/bss_wq_if.sv ***
// Valid/ready carrier between the controller and its write queue.
`timescale 1ns/1ps
interface bss_wq_if #(parameter int W = 24);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport fifo (input in_valid, output in_ready, input in_data,
                  output out_valid, input out_ready, output out_data);
    modport user (output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
endinterface : bss_wq_if

// *** hdl/bss_wq_fifo.sv ***
// Parameterised FIFO that queues captured writes ahead of the array.
`timescale 1ns/1ps
module bss_wq_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    bss_wq_if.fifo q
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("Write queue depth must be a power of two, at least 2.");
    end

    logic [W-1:0] buf_r [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign q.in_ready = (count_r != (PW+1)'(DEPTH));
    assign q.out_valid = (count_r != '0);
    assign q.out_data = buf_r[rd_ptr_r];
    assign push = q.in_valid & q.in_ready;
    assign pop = q.out_valid & q.out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            buf_r[wr_ptr_r] <= q.in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    property p_no_overflow;
        @(posedge clk_sys) disable iff (reset)
        count_r == (PW+1)'(DEPTH) |-> !q.in_ready;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("Queue accepts data while full.");

    property p_ptr_track;
        @(posedge clk_sys) disable iff (reset)
        count_r <= (PW+1)'(DEPTH) && (wr_ptr_r - rd_ptr_r) == count_r[PW-1:0];
    endproperty
    a_ptr_track: assert property (p_ptr_track) else $error("Queue count and pointers disagree.");

    property p_full_reached;
        @(posedge clk_sys) disable iff (reset)
        count_r == (PW+1)'(DEPTH);
    endproperty
    c_full_reached: cover property (p_full_reached);
endmodule : bss_wq_fifo

// *** sim/bss_host_model.sv ***
// Bus master model: data pin resolution and output enable control.
`timescale 1ns/1ps
module bss_host_model (
    input wire logic clk_sys,
    input wire logic [8:0] dev_data,
    input wire logic dev_oe,
    input wire logic [8:0] host_data,
    input wire logic host_drive,
    input wire logic want_read,
    input wire logic force_oe,
    output logic output_enable_n,
    output logic [8:0] pin_data
);
    logic [8:0] last_r;
    // Released pins show the inverse of the last level, flipping every cycle.
    always_ff @(posedge clk_sys) begin
        last_r <= (dev_oe || host_drive) ? pin_data : ~last_r;
    end
    // Output enable stays off while write data is driven, unless a scenario forces it on.
    assign output_enable_n = host_drive ? !force_oe : !want_read;
    always_comb begin
        if (dev_oe && host_drive) begin
            pin_data = 'x;
        end else if (host_drive) begin
            pin_data = host_data;
        end else if (dev_oe) begin
            pin_data = dev_data;
        end else begin
            pin_data = ~last_r;
        end
    end
endmodule : bss_host_model

// *** sim/tb_top.sv ***
// Self-checking bench for the burst synchronous SRAM controller.
`timescale 1ns/1ps
module tb_top;
    localparam logic [14:0] BASE = 15'h1a50;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [14:0] word_address = 15'h0000;
    logic [8:0] host_data = 9'h000;
    logic host_drive = 1'b0;
    logic want_read = 1'b0;
    logic force_oe = 1'b0;
    logic write_strobe_n = 1'b1;
    logic sel_hi = 1'b0;
    logic sel_lo_n = 1'b1;
    logic st_proc_n = 1'b1;
    logic st_ctrl_n = 1'b1;
    logic adv_n = 1'b1;
    logic [8:0] pin_data;
    logic [8:0] dev_data;
    logic dev_oe;
    logic output_enable_n;
    logic wq_ready;
    int mismatches = 0;
    int checked = 0;
    logic [8:0] wd [4] = '{9'h1c3, 9'h05a, 9'h13e, 9'h0f1};

    // ------------------------------------------------------------
    // Clock, reset and instances
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    bss_sram_ctrl bss_sram_ctrl_inst (
        .clk_sys(clk_sys), .reset(reset), .word_address(word_address),
        .shared_data_bus_in(pin_data), .shared_data_bus_out(dev_data), .shared_data_bus_oe(dev_oe),
        .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
        .select_active_high(sel_hi), .select_active_low_n(sel_lo_n), .start_from_processor_n(st_proc_n),
        .start_from_cache_ctrl_n(st_ctrl_n), .burst_advance_n(adv_n), .write_queue_ready(wq_ready)
    );

    bss_host_model bss_host_model_inst (
        .clk_sys(clk_sys), .dev_data(dev_data), .dev_oe(dev_oe), .host_data(host_data),
        .host_drive(host_drive), .want_read(want_read), .force_oe(force_oe),
        .output_enable_n(output_enable_n), .pin_data(pin_data)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // The control word is {processor start_n, controller start_n, advance_n, write_strobe_n}.
    task automatic issue(input logic [3:0] ctl, input logic [1:0] s, input logic [14:0] a, input logic [8:0] d);
        @(posedge clk_sys);
        {st_proc_n, st_ctrl_n, adv_n, write_strobe_n} <= ctl;
        {sel_hi, sel_lo_n} <= s;
        word_address <= a;
        host_data <= d;
        host_drive <= !ctl[0];
    endtask : issue

    task automatic final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_write;
        force_oe <= 1'b1;
        #1 check(dev_oe, 1'b0);
        issue(4'ha, 2'b10, BASE | 15'h0002, wd[0]);
        for (int i = 1; i < 4; i++) begin
            #1 check(dev_oe, 1'b0);
            issue(4'hc, 2'b00, 15'h0000, i == 3 ? 9'h000 : wd[i]);
        end
        #1 check(dev_oe, 1'b0);
        // The last word lands only if the suspend rewrites the current address.
        issue(4'he, 2'b00, 15'h0000, wd[3]);
        repeat (5) issue(4'h7, 2'b00, 15'h0000, 9'h000);
        #1 check(dev_oe, 1'b0);
        check(wq_ready, 1'b1);
        $display("write burst done");
    endtask : t_write

    task automatic t_read;
        logic [3:0] ctl [8] = '{4'h7, 4'hd, 4'hd, 4'hd, 4'hd, 4'hf, 4'h7, 4'h7};
        int idx [6] = '{0, 1, 2, 3, 0, 0};
        want_read <= 1'b1;
        force_oe <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            issue(ctl[i], i < 6 ? 2'b10 : 2'b00, i == 0 ? BASE | 15'h0002 : BASE | 15'h0001, 9'h000);
            if (i >= 2) begin
                #1 check(dev_data, wd[idx[i-2]]);
                check(dev_oe, 1'b1);
            end
        end
        #5 want_read <= 1'b0;
        #1 check(dev_oe, 1'b0);
        want_read <= 1'b1;
        #1 check(dev_oe, 1'b1);
        issue(4'h7, 2'b00, 15'h0000, 9'h000);
        #1 check(dev_oe, 1'b0);
        $display("read burst done");
    endtask : t_read

    task automatic t_modes;
        force_oe <= 1'b1;
        issue(4'hb, 2'b10, BASE, 9'h000);
        issue(4'h2, 2'b10, BASE | 15'h0001, 9'h1ff);
        issue(4'h7, 2'b11, 15'h0000, 9'h000);
        #1 check(dev_data, wd[2]);
        check(dev_oe, 1'b1);
        issue(4'hf, 2'b11, 15'h0000, 9'h000);
        #1 check(dev_data, wd[3]);
        check(dev_oe, 1'b0);
        repeat (2) begin
            issue(4'hf, 2'b00, 15'h0000, 9'h000);
            #1 check(dev_oe, 1'b0);
        end
        issue(4'h7, 2'b10, BASE | 15'h0001, 9'h000);
        repeat (2) issue(4'h7, 2'b00, 15'h0000, 9'h000);
        #1 check(dev_data, wd[3]);
        check(dev_oe, 1'b1);
        $display("start modes done");
    endtask : t_modes

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        t_write();
        t_read();
        t_modes();
        final_report();
    end

    initial begin
        repeat (2000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end
endmodule : tb_top
